// File: hdl/card_atr_top.sv
// Summary of operation
// R1: The terminal supplies the card clock at any rate from 1 MHz to 5 MHz; the terminal model drives a 48 ns period, about 20.8 MHz.
// R2: All card-side timing runs from the terminal clock, never from an internal clock.
// R3: The terminal clock high time stays between 40 % and 60 % of the period.
// R4: The terminal settles the supply class before any unrelated card activity.
// R5: The terminal makes its first attempt in its lowest supported class.
// R6: With no answer-to-reset the terminal deactivates and retries one class higher.
// R7: If the class in use is not reported, the terminal retries in a reported class.
// R8: On a corrupted answer the terminal retries at least 3 times in the same class.
// R9: After 3 corrupted answers a retry may use only the next higher class.
// R10: The classes are reported in the first class interface byte after index 2.
// R11: Classes A to E map to bits 1 to 5, with D and E reserved.
// R12: The reported class set is always contiguous, never a split set.
// R13: After each reset the answer-to-reset is the first string the card sends.
// R14: Global bytes, the class byte among them, follow a type 15 indication.
// R15: The terminal rejects the card once its highest class yields no usable answer.
`timescale 1ns/10ps
`default_nettype none
module card_atr_top
    import card_atr_pkg::*;
(
    input wire logic clk_sys_i,                 // System clock
    input wire logic rstn_i,                    // Async reset, active low
    input wire logic [CLASS_W-1:0] class_sel_i, // Classes the card wants to offer
    output logic [CLASS_W-1:0] class_report_o,  // Class set actually reported
    output logic atr_busy_o,                    // Answer-to-reset in progress
    output logic atr_sent_o,                    // Pulse: answer-to-reset finished
    input wire logic card_clk_i,                // Clock from terminal
    input wire logic card_rstn_i,               // Card reset pin, active low
    input wire logic io_i,                      // I/O line level
    output logic io_o,                          // I/O drive value, always low
    output logic io_oe_o                        // I/O drive enable
);
    // System side: legalise the requested class set
    logic [CLASS_W-1:0] usable;
    logic [CLASS_W-1:0] keep;
    assign usable = class_sel_i & CLASS_USABLE; // R11
    assign keep[0] = usable[0];
    genvar gi;
    generate
        for (gi = 1; gi < CLASS_W; gi++) begin : g_run
            // Keep only the lowest run of adjacent classes
            assign keep[gi] = usable[gi] & (keep[gi-1] | ~|usable[gi-1:0]); // R12
        end
    endgenerate

    logic [CLASS_W-1:0] data_reg;
    logic req_tgl_reg;
    logic ack_s1_reg;
    logic ack_s2_reg;
    logic done_s1_reg;
    logic done_s2_reg;
    logic done_s3_reg;
    logic busy_s1_reg;
    logic busy_s2_reg;

    // Only launch a new word once the previous one is acknowledged
    wire hs_idle = (ack_s2_reg == req_tgl_reg);
    wire hs_launch = hs_idle && (keep != data_reg);

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_reg <= '0;
            req_tgl_reg <= 1'b0;
        end else if (hs_launch) begin
            data_reg <= keep;
            req_tgl_reg <= ~req_tgl_reg;
        end
    end

    logic req_s1_reg;
    logic req_s2_reg;
    logic req_seen_reg;
    logic done_tgl_reg;
    logic busy_reg;

    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            ack_s1_reg <= 1'b0;
            ack_s2_reg <= 1'b0;
            done_s1_reg <= 1'b0;
            done_s2_reg <= 1'b0;
            done_s3_reg <= 1'b0;
            busy_s1_reg <= 1'b0;
            busy_s2_reg <= 1'b0;
        end else begin
            ack_s1_reg <= req_seen_reg;
            ack_s2_reg <= ack_s1_reg;
            done_s1_reg <= done_tgl_reg;
            done_s2_reg <= done_s1_reg;
            done_s3_reg <= done_s2_reg;
            busy_s1_reg <= busy_reg;
            busy_s2_reg <= busy_s1_reg;
        end
    end

    assign class_report_o = data_reg;
    assign atr_busy_o = busy_s2_reg;
    assign atr_sent_o = done_s2_reg ^ done_s3_reg;

    // Card side: everything below runs on the terminal clock only
    logic [CLASS_W-1:0] class_link_reg;
    logic [CLASS_W-1:0] atr_class_reg;
    logic rst_s1_reg;
    logic rst_s2_reg;
    logic io_s1_reg;
    logic io_s2_reg;

    // Data word is stable while the toggle differs, so no per-bit sync needed
    always_ff @(posedge card_clk_i or negedge rstn_i) begin // R2
        if (!rstn_i) begin
            req_s1_reg <= 1'b0;
            req_s2_reg <= 1'b0;
            req_seen_reg <= 1'b0;
            class_link_reg <= '0;
            rst_s1_reg <= 1'b0;
            rst_s2_reg <= 1'b0;
            io_s1_reg <= 1'b1;
            io_s2_reg <= 1'b1;
        end else begin
            req_s1_reg <= req_tgl_reg;
            req_s2_reg <= req_s1_reg;
            rst_s1_reg <= card_rstn_i;
            rst_s2_reg <= rst_s1_reg;
            io_s1_reg <= io_i;
            io_s2_reg <= io_s1_reg;
            if (req_s2_reg != req_seen_reg) begin
                req_seen_reg <= req_s2_reg;
                class_link_reg <= data_reg;
            end
        end
    end

    atr_state_t state_reg;
    atr_state_t state_next;
    logic [CNT_W-1:0] wait_reg;
    logic [2:0] idx_reg;
    char_link_if link ();

    // Answer byte string: initial byte, format byte, T=0 TD, T=15 TD, class byte, check
    logic [7:0] class_byte;
    logic [7:0] check_byte;
    assign class_byte = {CLASS_BYTE_HIGH[7:CLASS_W], atr_class_reg}; // R10 R11
    assign check_byte = ATR_FORMAT ^ ATR_TD_FIRST ^ ATR_TD_GLOBAL ^ class_byte;

    logic [7:0] atr_byte;
    always_comb begin
        case (idx_reg)
            IDX_INITIAL: atr_byte = ATR_INITIAL;
            IDX_FORMAT: atr_byte = ATR_FORMAT;
            IDX_TD_FIRST: atr_byte = ATR_TD_FIRST;
            IDX_TD_GLOBAL: atr_byte = ATR_TD_GLOBAL; // R14
            IDX_CLASS: atr_byte = class_byte; // R10
            IDX_CHECK: atr_byte = check_byte;
            default: atr_byte = ATR_INITIAL;
        endcase
    end

    wire wait_over = (wait_reg == ATR_DELAY_CLKS);
    wire last_byte = (idx_reg == IDX_CHECK);

    always_comb begin
        state_next = state_reg;
        case (state_reg)
            ST_IDLE: if (rst_s2_reg) state_next = ST_WAIT;
            ST_WAIT: if (wait_over) state_next = ST_SEND;
            ST_SEND: state_next = ST_HOLD;
            ST_HOLD: begin
                if (!link.busy) begin
                    state_next = last_byte ? ST_DONE : ST_SEND;
                end
            end
            ST_DONE: state_next = ST_DONE;
            default: state_next = ST_IDLE;
        endcase
        // Reset pin low aborts and rearms; nothing else is ever sent
        if (!rst_s2_reg) begin
            state_next = ST_IDLE; // R13
        end
    end

    always_ff @(posedge card_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_reg <= ST_IDLE;
            wait_reg <= '0;
            idx_reg <= IDX_INITIAL;
            atr_class_reg <= '0;
            done_tgl_reg <= 1'b0;
            busy_reg <= 1'b0;
        end else begin
            state_reg <= state_next;
            busy_reg <= (state_next != ST_IDLE) && (state_next != ST_DONE);
            wait_reg <= (state_reg == ST_WAIT) ? wait_reg + 16'h0001 : '0;
            if (state_reg == ST_IDLE) begin
                idx_reg <= IDX_INITIAL;
                // Freeze the class set for the whole answer
                atr_class_reg <= class_link_reg;
            end else if (state_reg == ST_HOLD && state_next == ST_SEND) begin
                idx_reg <= idx_reg + 3'h1;
            end
            if (state_reg == ST_HOLD && state_next == ST_DONE) begin
                done_tgl_reg <= ~done_tgl_reg;
            end
        end
    end

    assign link.start = (state_reg == ST_SEND);
    assign link.data = atr_byte;

    // Reset pin also drops a character in flight, so nothing trails an abort
    wire tx_rstn = rstn_i & rst_s2_reg; // R13

    char_tx u_tx (
        .card_clk_i(card_clk_i),
        .rstn_i(tx_rstn),
        .io_sync_i(io_s2_reg),
        .link(link),
        .io_oe_o(io_oe_o)
    );

    assign io_o = 1'b0;
endmodule
`default_nettype wire

// File: hdl/char_tx.sv
`timescale 1ns/10ps
`default_nettype none
module char_tx
    import card_atr_pkg::*;
(
    input wire logic card_clk_i,  // Card clock from terminal
    input wire logic rstn_i,      // Async reset, active low
    input wire logic io_sync_i,   // Synchronised line level
    char_link_if.tx link,         // Character request
    output logic io_oe_o          // Pull line low
);
    logic [CNT_W-1:0] etu_reg;
    logic [3:0] bit_reg;
    logic [8:0] shift_reg;
    logic active_reg;
    logic nack_reg;
    logic [1:0] rep_reg;
    logic oe_reg;

    wire etu_end = (etu_reg == ETU_CLKS - 16'h0001);
    wire mid_guard = (bit_reg == BIT_GUARD1) && (etu_reg == ETU_HALF_CLKS);
    wire char_end = etu_end && (bit_reg == BIT_LAST);
    // Repeat on error signal, bounded so a stuck line cannot hang the card
    wire retry = nack_reg && (rep_reg != REPEAT_MAX);
    wire [3:0] bit_next = char_end ? BIT_START : bit_reg + 4'h1;
    wire data_bit = (bit_reg == BIT_START) ? 1'b0 :
                    (bit_reg <= BIT_PARITY) ? shift_reg[bit_reg - 4'h1] : 1'b1;

    always_ff @(posedge card_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            etu_reg <= '0;
            bit_reg <= BIT_START;
            shift_reg <= '0;
            active_reg <= 1'b0;
            nack_reg <= 1'b0;
            rep_reg <= '0;
        end else if (!active_reg) begin
            etu_reg <= '0;
            bit_reg <= BIT_START;
            nack_reg <= 1'b0;
            rep_reg <= '0;
            if (link.start) begin
                shift_reg <= {^link.data, link.data};
                active_reg <= 1'b1;
            end
        end else begin
            etu_reg <= etu_end ? '0 : etu_reg + 16'h0001;
            if (mid_guard && !io_sync_i) begin
                nack_reg <= 1'b1;
            end
            if (etu_end) begin
                bit_reg <= bit_next;
            end
            if (char_end) begin
                nack_reg <= 1'b0;
                rep_reg <= rep_reg + 2'h1;
                active_reg <= retry;
            end
        end
    end

    always_ff @(posedge card_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            oe_reg <= 1'b0;
        end else begin
            oe_reg <= active_reg && !data_bit;
        end
    end

    assign io_oe_o = oe_reg;
    assign link.busy = active_reg || link.start;
endmodule
`default_nettype wire

// File: shared/card_atr_pkg.sv
package card_atr_pkg;
    localparam int CLASS_W = 5;
    localparam logic [CLASS_W-1:0] CLASS_A = 5'h01;
    localparam logic [CLASS_W-1:0] CLASS_B = 5'h02;
    localparam logic [CLASS_W-1:0] CLASS_C = 5'h04;
    localparam logic [CLASS_W-1:0] CLASS_D = 5'h08;
    localparam logic [CLASS_W-1:0] CLASS_E = 5'h10;
    localparam logic [CLASS_W-1:0] CLASS_USABLE = CLASS_A | CLASS_B | CLASS_C;

    localparam int ATR_LEN = 6;
    localparam logic [7:0] ATR_INITIAL = 8'h3B;
    localparam logic [7:0] ATR_FORMAT = 8'h80;
    localparam logic [7:0] ATR_TD_FIRST = 8'h80;
    localparam logic [7:0] ATR_TD_GLOBAL = 8'h1F;
    localparam logic [7:0] CLASS_BYTE_HIGH = 8'h00;
    localparam logic [2:0] IDX_INITIAL = 3'h0;
    localparam logic [2:0] IDX_FORMAT = 3'h1;
    localparam logic [2:0] IDX_TD_FIRST = 3'h2;
    localparam logic [2:0] IDX_TD_GLOBAL = 3'h3;
    localparam logic [2:0] IDX_CLASS = 3'h4;
    localparam logic [2:0] IDX_CHECK = 3'h5;

    localparam int CNT_W = 16;
    localparam logic [CNT_W-1:0] ETU_CLKS = 16'h0174;
    localparam logic [CNT_W-1:0] ETU_HALF_CLKS = 16'h00BA;
    localparam logic [CNT_W-1:0] ATR_DELAY_CLKS = 16'h0190;

    localparam logic [3:0] BIT_START = 4'h0;
    localparam logic [3:0] BIT_PARITY = 4'h9;
    localparam logic [3:0] BIT_GUARD1 = 4'hA;
    localparam logic [3:0] BIT_LAST = 4'hB;
    localparam logic [1:0] REPEAT_MAX = 2'h3;

    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_WAIT = 5'b00010,
        ST_SEND = 5'b00100,
        ST_HOLD = 5'b01000,
        ST_DONE = 5'b10000
    } atr_state_t;
endpackage

// File: shared/char_link_if.sv
`timescale 1ns/10ps
`default_nettype none
interface char_link_if;
    logic start;
    logic [7:0] data;
    logic busy;
    modport master (output start, output data, input busy);
    modport tx (input start, input data, output busy);
endinterface
`default_nettype wire

// File: verif/card_atr_props.sv
`timescale 1ns/10ps
`default_nettype none
module card_atr_props
    import card_atr_pkg::*;
(
    input wire logic clk_sys_i, // Sys clock
    input wire logic rstn_i, // Reset
    input wire logic [CLASS_W-1:0] class_sel_i, // Asked set
    input wire logic [CLASS_W-1:0] class_report_o, // Sent set
    input wire logic atr_busy_o, // Answer runs
    input wire logic atr_sent_o, // Answer done
    input wire logic card_clk_i, // Card clock
    input wire logic card_rstn_i, // Card reset
    input wire logic io_i, // Line level
    input wire logic io_o, // Drive value
    input wire logic io_oe_o // Drive enable
);
    logic [15:0] since_reg;
    logic [15:0] run_reg;
    logic oe_reg;
    wire logic oe_edge = io_oe_o != oe_reg;
    // Saturate so a long idle never wraps into a short run
    wire logic [15:0] since_next = !card_rstn_i ? 16'h0000 : since_reg + {15'h0000, ~&since_reg};
    wire logic [15:0] run_next = oe_edge ? 16'h0000 : run_reg + {15'h0000, ~&run_reg};
    always_ff @(posedge card_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            since_reg <= 16'h0000;
            run_reg <= 16'h0000;
            oe_reg <= 1'b0;
        end else begin
            since_reg <= since_next;
            run_reg <= run_next;
            oe_reg <= io_oe_o;
        end
    end
    a_no_reserved: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        (class_report_o & (CLASS_D | CLASS_E)) == 5'h00) else $error("reserved class reported");
    a_set_contiguous: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        class_report_o inside {5'h00, 5'h01, 5'h02, 5'h03, 5'h04, 5'h06, 5'h07})
        else $error("class set not contiguous");
    a_report_from_sel: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        $changed(class_report_o) |-> (class_report_o & ~$past(class_sel_i)) == 5'h00)
        else $error("reported class not requested");
    a_busy_abort: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        !card_rstn_i [*8] |-> !atr_busy_o) else $error("busy while card held in reset");
    a_sent_single: assert property (@(posedge clk_sys_i) disable iff (!rstn_i)
        atr_sent_o |=> !atr_sent_o) else $error("done pulse too long");
    a_abort_release: assert property (@(posedge card_clk_i) disable iff (!rstn_i)
        !card_rstn_i [*4] |-> !io_oe_o) else $error("line driven during card reset");
    a_start_delay: assert property (@(posedge card_clk_i) disable iff (!rstn_i)
        $rose(io_oe_o) |-> since_reg >= 16'h0190) else $error("start bit too early");
    a_bit_length: assert property (@(posedge card_clk_i) disable iff (!rstn_i)
        oe_edge && card_rstn_i |-> run_reg >= 16'h0172) else $error("bit shorter than one etu");
endmodule
bind card_atr_top card_atr_props u_props (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i),
    .class_sel_i(class_sel_i), .class_report_o(class_report_o), .atr_busy_o(atr_busy_o),
    .atr_sent_o(atr_sent_o), .card_clk_i(card_clk_i), .card_rstn_i(card_rstn_i),
    .io_i(io_i), .io_o(io_o), .io_oe_o(io_oe_o));
`default_nettype wire

// File: verif/card_voltage_class_selection_test.sv
`timescale 1ns/10ps
`default_nettype none
module card_voltage_class_selection_test
    import card_atr_pkg::*;
;
    logic clk_sys_i, rstn_i, card_clk, card_rstn, io_line, io_o, io_oe;
    logic atr_busy, atr_sent, act, rx_valid, err;
    logic [CLASS_W-1:0] class_sel, class_report, last_exp;
    logic [7:0] rx_byte;
    logic [7:0] cls_q[$];
    logic [7:0] byte_q[$];
    logic [CLASS_W-1:0] tbl [8] = '{5'h05, 5'h18, 5'h06, 5'h0A, 5'h03, 5'h1F, 5'h10, 5'h04};
    int mismatches, total_checks, rx_cnt;
    card_atr_top uut (.clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .class_sel_i(class_sel),
        .class_report_o(class_report), .atr_busy_o(atr_busy), .atr_sent_o(atr_sent),
        .card_clk_i(card_clk), .card_rstn_i(card_rstn), .io_i(io_line), .io_o(io_o),
        .io_oe_o(io_oe));
    terminal_model term (.act_i(act), .err_i(err), .io_oe_i(io_oe), .card_clk_o(card_clk),
        .card_rstn_o(card_rstn), .io_line_o(io_line), .rx_byte_o(rx_byte), .rx_valid_o(rx_valid));
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] expd);
        total_checks++;
        if (seen !== expd) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", name, expd, seen);
        end
    endtask
    task automatic final_report;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // Lowest contiguous run among A to C; D and E never offered
    function automatic logic [CLASS_W-1:0] legal(input logic [CLASS_W-1:0] s);
        if (s[0]) return s[1] ? (s[2] ? 5'h07 : 5'h03) : 5'h01;
        if (s[1]) return s[2] ? 5'h06 : 5'h02;
        return {2'h0, s[2], 2'h0};
    endfunction
    task automatic set_class(input logic [CLASS_W-1:0] s);
        @(posedge clk_sys_i);
        #2;
        class_sel = s;
        if (legal(s) != last_exp) cls_q.push_back({3'h0, legal(s)});
        last_exp = legal(s);
        for (int k = 0; k < 40 && class_report !== last_exp; k++) @(posedge clk_sys_i);
        repeat (12) @(posedge clk_sys_i);
    endtask
    task automatic run_atr(input int n, input bit e);
        logic [7:0] cb;
        cb = {3'h0, last_exp};
        byte_q = '{ATR_INITIAL, 8'h80, 8'h80, 8'h1F, cb, 8'h1F ^ cb};
        byte_q = byte_q[0:n-1];
        // A rejected first character is sent again
        if (e) byte_q.push_front(ATR_INITIAL);
        rx_cnt = 0;
        @(posedge clk_sys_i);
        #2;
        err = e;
        act = 1'b1;
        while (rx_cnt < 1) @(posedge clk_sys_i);
        check("busy", {7'h00, atr_busy}, 8'h01);
        #2;
        err = 1'b0;
        while (rx_cnt < n + int'(e)) @(posedge clk_sys_i);
        if (n == 6) begin
            for (int k = 0; k < 3000 && atr_sent !== 1'b1; k++) @(posedge clk_sys_i);
            check("done", {7'h00, atr_sent}, 8'h01);
        end
        #2;
        act = 1'b0;
        repeat (100) @(posedge clk_sys_i);
        check("idle", {5'h00, io_o, atr_busy, io_oe}, 8'h00);
        $display("answer test with %0d characters done", n);
    endtask
    always @(posedge clk_sys_i) begin
        if (rstn_i && $changed(class_report)) check("class", {3'h0, class_report}, cls_q.pop_front());
    end
    always @(posedge rx_valid) begin
        rx_cnt++;
        check("answer byte", rx_byte, byte_q.pop_front());
    end
    initial begin
        clk_sys_i = 1'b0;
        forever #20 clk_sys_i = ~clk_sys_i;
    end
    initial begin
        repeat (90000) @(posedge clk_sys_i);
        mismatches++;
        final_report();
    end
    initial begin
        rstn_i = 1'b0;
        act = 1'b0;
        err = 1'b0;
        class_sel = 5'h02;
        last_exp = 5'h02;
        cls_q.push_back(8'h02);
        repeat (6) @(posedge clk_sys_i);
        #2;
        rstn_i = 1'b1;
        void'($urandom(21814));
        foreach (tbl[i]) set_class(tbl[i]);
        for (int i = 0; i < 8; i++) set_class(5'($urandom % 32));
        $display("class table test done");
        set_class(5'h0E);
        run_atr(2, 1'b0);
        set_class(5'h19);
        run_atr(6, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire

// File: verif/terminal_model.sv
`timescale 1ns/10ps
`default_nettype none
module terminal_model (
    input wire logic act_i, // Activate card
    input wire logic err_i, // Reject the next character
    input wire logic io_oe_i, // Card pulls line low
    output logic card_clk_o, // Card clock
    output logic card_rstn_o, // Card reset, active low
    output logic io_line_o, // Resolved line
    output logic [7:0] rx_byte_o, // Received character
    output logic rx_valid_o // Pulse per character
);
    logic err_drive;
    logic rej;
    initial begin
        card_clk_o = 1'b0;
        #7;
        forever #24 card_clk_o = ~card_clk_o;
    end
    // Pull-up wins whenever neither side pulls low
    assign io_line_o = (io_oe_i === 1'b1 || err_drive) ? 1'b0 : 1'b1;
    always @(posedge card_clk_o) card_rstn_o <= act_i;
    initial begin
        rx_valid_o = 1'b0;
        rx_byte_o = 8'h00;
        err_drive = 1'b0;
        rej = 1'b0;
        forever begin
            @(negedge io_line_o);
            repeat (186) @(posedge card_clk_o);
            for (int i = 0; i < 8; i++) begin
                repeat (372) @(posedge card_clk_o);
                rx_byte_o[i] = io_line_o;
            end
            // Step over parity, a low one is no start bit
            repeat (372) @(posedge card_clk_o);
            rej = err_i;
            rx_valid_o = 1'b1;
            @(posedge card_clk_o);
            rx_valid_o = 1'b0;
            if (rej) begin
                // Error signal over the first guard time
                repeat (185) @(posedge card_clk_o);
                err_drive <= 1'b1;
                repeat (372) @(posedge card_clk_o);
                err_drive <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire
